// ===== common/asr_map.svh
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

// Width of one serial word (channel result or configuration)
`define ASR_WORD_BITS      16
// Number of channel slots in the converter
`define ASR_NUM_CH         8
// Channels carried by each pin in dual-output readout
`define ASR_HALF_CH        4

// Configuration field positions
`define ASR_CFG_UPDATE     15
`define ASR_CFG_CH_HI      14
`define ASR_CFG_CH_LO      13
`define ASR_CFG_GAIN_HI    11
`define ASR_CFG_GAIN_LO    4
`define ASR_CFG_REF_EN     2
`define ASR_CFG_CONV_MODE  1
`define ASR_CFG_SDO2_OFF   0

// Configuration value after reset
`define ASR_CFG_DEFAULT    16'hFFFF

// Conversions treated as undefined after leaving power-down
`define ASR_WARMUP_CONV    2'h2

// System clock rate and conversion quiet times
`define ASR_CLK_MHZ        250
`define ASR_CONV_NORMAL_NS 1000
`define ASR_CONV_WARP_NS   800

`endif

// ===== common/asr_pkg.sv
package asr_pkg;

   // One serial word
   typedef logic [15:0] asr_word_t;

   // Conversion engine state
   typedef enum logic [0:0] {
      ASR_ST_TRACK = 1'b0,
      ASR_ST_CONV  = 1'b1
   } asr_state_e;

endpackage

// ===== src/asr_sync.sv
`timescale 1ns/10ps

// Two-flop synchroniser, one chain per bit
module asr_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock
   input  wire logic             clock,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         logic meta_r;  // First stage, read only by the second
         logic hold_r;  // Second stage, safe to use
         // No reset: a chain settles within two edges anyway
         always_ff @(posedge clock) begin
            meta_r <= async_in[i];
            hold_r <= meta_r;
         end
         assign sync_out[i] = hold_r;
      end
   endgenerate

endmodule

// ===== src/asr_readout_port.sv
`timescale 1ns/10ps
`include "asr_map.svh"

module asr_readout_port #(
   parameter int unsigned CLK_MHZ   = `ASR_CLK_MHZ,
   parameter int unsigned NORMAL_NS = `ASR_CONV_NORMAL_NS,
   parameter int unsigned WARP_NS   = `ASR_CONV_WARP_NS
) (
   // System
   input  wire logic         clock,
   input  wire logic         reset,
   // Host control pins
   input  wire logic         reset_pin_in,
   input  wire logic         power_down_in,
   input  wire logic         convert_start,
   // Serial port
   input  wire logic         cs_n_in,
   input  wire logic         sclk_in,
   input  wire logic         serial_data_in,
   output logic              serial_data_out,
   output logic              serial_data_oe,
   output logic              busy_second_out,
   // Converter core
   input  wire logic [127:0] channel_data_in,
   output logic              sample_hold,
   output logic              power_down_active,
   output logic [1:0]        channel_count_sel,
   output logic [7:0]        gain_select,
   output logic              int_ref_enable,
   output logic              conv_mode_select
);

   // Quiet time in cycles, rounded up, never below one
   localparam int unsigned NORMAL_RAW = (NORMAL_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WARP_RAW   = (WARP_NS * CLK_MHZ + 999) / 1000;
   localparam logic [15:0] NORMAL_CYC =
      16'(NORMAL_RAW < 1 ? 1 : NORMAL_RAW);
   localparam logic [15:0] WARP_CYC   = 16'(WARP_RAW < 1 ? 1 : WARP_RAW);
   localparam logic [3:0]  WORD_LAST  = 4'(`ASR_WORD_BITS - 1);
   localparam logic [4:0]  WORD_LEN   = 5'(`ASR_WORD_BITS);
   localparam logic [3:0]  HALF_CH    = 4'(`ASR_HALF_CH);
   localparam logic [7:0]  OUT_MAX    = 8'hFF;

   // Synchronised pin levels
   logic [5:0] pins_s;
   logic       rst_s;      // Reset pin level
   logic       pd_s;       // Power-down pin level
   logic       cnv_s;      // Convert start level
   logic       cs_s;       // Chip select level, low active
   logic       sck_s;      // Serial clock level
   logic       din_s;      // Serial input level

   // Delayed copies for edge detection
   logic rst_d_r;
   logic pd_d_r;
   logic cnv_d_r;
   logic cs_d_r;
   logic sck_d_r;

   // Conversion engine
   asr_pkg::asr_state_e state_r;
   asr_pkg::asr_state_e state_nxt;
   logic [15:0]         conv_cnt_r;  // Cycles left in quiet phase
   logic [1:0]          warm_cnt_r;  // Conversions still undefined

   // Results and configuration
   asr_pkg::asr_word_t res_r [`ASR_NUM_CH];  // Stored results
   asr_pkg::asr_word_t cfg_r;                // Active configuration
   asr_pkg::asr_word_t pend_r;               // Written, not yet applied
   logic               pend_valid_r;         // Pending word waits for EOC

   // Serial input side
   logic [15:0] in_sh_r;    // Shift register for host word
   logic [4:0]  in_cnt_r;   // Rising edges seen this transfer
   logic        in_ok_r;    // Transfer began outside a conversion

   // Serial output side
   logic [7:0]  out_cnt_r;  // Falling edges seen this transfer
   logic        tx_en_r;    // Transfer active and allowed to drive
   logic        dual_r;     // Dual-pin format chosen at select fall
   logic        sdo_r;
   logic        sdo_oe_r;
   logic        busy_pin_r;

   // Decoded events
   wire halt     = rst_s | pd_s;
   wire rst_rise = rst_s & ~rst_d_r;
   wire pd_rise  = pd_s & ~pd_d_r;
   wire cnv_rise = cnv_s & ~cnv_d_r;
   wire cs_fall  = ~cs_s & cs_d_r;
   wire sck_rise = sck_s & ~sck_d_r;
   wire sck_fall = ~sck_s & sck_d_r;
   wire busy     = (state_r == asr_pkg::ASR_ST_CONV);
   wire start_ok = cnv_rise & ~halt & ~busy;
   wire eoc      = busy & (conv_cnt_r == 16'h0001) & ~halt;
   wire abort    = rst_rise | pd_rise;

   // Quiet time follows the active conversion mode
   wire [15:0] conv_len = cfg_r[`ASR_CFG_CONV_MODE] ? NORMAL_CYC : WARP_CYC;

   // Config capture on the last of the first 16 rising edges
   wire        in_live  = sck_rise & ~cs_s & (in_cnt_r < WORD_LEN);
   wire        in_last  = in_live & (in_cnt_r == 5'(WORD_LAST));
   wire [15:0] in_word  = {in_sh_r[14:0], din_s};
   wire        cfg_take = in_last & in_ok_r & ~busy &
                          in_word[`ASR_CFG_UPDATE];

   // Output word and bit selection
   wire [3:0] word_idx = out_cnt_r[7:4];
   wire [3:0] bit_idx  = WORD_LAST - out_cnt_r[3:0];
   wire [3:0] n_act    = {1'b0, cfg_r[`ASR_CFG_CH_HI:`ASR_CFG_CH_LO], 1'b0}
                         + 4'h2;
   wire [3:0] prim_lim = dual_r ? HALF_CH : n_act;
   wire [3:0] sec_idx  = word_idx + HALF_CH;

   // Word on the main output
   wire [15:0] prim_word =
      (word_idx < prim_lim)  ? res_r[word_idx[2:0]] :
      (word_idx == prim_lim) ? cfg_r : 16'h0000;
   // Word on the second output, dual format only
   wire [15:0] sec_word =
      (dual_r && word_idx < HALF_CH) ? res_r[sec_idx[2:0]] : 16'h0000;
   wire prim_bit = prim_word[bit_idx];
   wire sec_bit  = sec_word[bit_idx];

   // Pin synchronisers
   asr_sync #(
      .WIDTH (6)
   ) u_sync (
      .clock    (clock),
      .async_in ({reset_pin_in, power_down_in, convert_start,
                  cs_n_in, sclk_in, serial_data_in}),
      .sync_out (pins_s)
   );
   assign rst_s = pins_s[5];
   assign pd_s  = pins_s[4];
   assign cnv_s = pins_s[3];
   assign cs_s  = pins_s[2];
   assign sck_s = pins_s[1];
   assign din_s = pins_s[0];

   // Edge history; select idles high so no false fall after reset
   always_ff @(posedge clock) begin
      if (reset) begin
         rst_d_r <= 1'b0;
         pd_d_r  <= 1'b0;
         cnv_d_r <= 1'b0;
         cs_d_r  <= 1'b1;
         sck_d_r <= 1'b0;
      end else begin
         rst_d_r <= rst_s;
         pd_d_r  <= pd_s;
         cnv_d_r <= cnv_s;
         cs_d_r  <= cs_s;
         sck_d_r <= sck_s;
      end
   end

   // Next conversion state; reset or power-down wins over all
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         asr_pkg::ASR_ST_TRACK: begin
            if (start_ok)
               state_nxt = asr_pkg::ASR_ST_CONV;
         end
         asr_pkg::ASR_ST_CONV: begin
            if (halt || eoc)
               state_nxt = asr_pkg::ASR_ST_TRACK;
         end
      endcase
   end

   // Conversion engine; further starts ignored while busy
   always_ff @(posedge clock) begin
      if (reset) begin
         state_r    <= asr_pkg::ASR_ST_TRACK;
         conv_cnt_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         if (start_ok)
            conv_cnt_r <= conv_len;
         else if (busy)
            conv_cnt_r <= conv_cnt_r - 16'h0001;
      end
   end

   // Undefined-conversion window after power-down
   always_ff @(posedge clock) begin
      if (reset)
         warm_cnt_r <= 2'h0;
      else if (pd_s)
         warm_cnt_r <= `ASR_WARMUP_CONV;
      else if (eoc && warm_cnt_r != 2'h0)
         warm_cnt_r <= warm_cnt_r - 2'h1;
   end

   // Per-channel result store; results pass as two's complement
   genvar ch;
   generate
      for (ch = 0; ch < `ASR_NUM_CH; ch = ch + 1) begin : g_res
         always_ff @(posedge clock) begin
            if (reset || rst_s)
               res_r[ch] <= 16'h0000;
            else if (eoc)
               // Pipeline not yet filled: hand out zero, not stale data
               res_r[ch] <= (warm_cnt_r != 2'h0) ? 16'h0000 :
                            channel_data_in[ch*16 +: 16];
         end
      end
   endgenerate

   // Active configuration; power-down leaves it untouched
   always_ff @(posedge clock) begin
      if (reset || rst_s)
         cfg_r <= `ASR_CFG_DEFAULT;
      else if (eoc && pend_valid_r)
         cfg_r <= pend_r;
   end

   // One-deep pending word, applied only at the next conversion end
   always_ff @(posedge clock) begin
      if (reset || rst_s) begin
         pend_r       <= `ASR_CFG_DEFAULT;
         pend_valid_r <= 1'b0;
      end else if (cfg_take) begin
         pend_r       <= in_word;
         pend_valid_r <= 1'b1;
      end else if (eoc) begin
         pend_valid_r <= 1'b0;
      end
   end

   // Host word shift-in on serial clock rising edges
   always_ff @(posedge clock) begin
      if (reset) begin
         in_sh_r  <= 16'h0000;
         in_cnt_r <= 5'h00;
         in_ok_r  <= 1'b0;
      end else if (cs_fall) begin
         in_cnt_r <= 5'h00;
         in_ok_r  <= ~busy & ~halt;
      end else begin
         if (in_live) begin
            in_sh_r  <= in_word;
            in_cnt_r <= in_cnt_r + 5'h01;
         end
         // A conversion start during the word discards it
         if (start_ok || halt)
            in_ok_r <= 1'b0;
      end
   end

   // Transfer enable and falling-edge bit counter
   always_ff @(posedge clock) begin
      if (reset) begin
         tx_en_r   <= 1'b0;
         out_cnt_r <= 8'h00;
         dual_r    <= 1'b0;
      end else if (halt || cs_s || abort) begin
         tx_en_r <= 1'b0;
      end else if (cs_fall) begin
         tx_en_r   <= 1'b1;
         out_cnt_r <= 8'h00;
         dual_r    <= ~cfg_r[`ASR_CFG_SDO2_OFF];
      end else if (tx_en_r && sck_fall && out_cnt_r != OUT_MAX) begin
         out_cnt_r <= out_cnt_r + 8'h01;
      end
   end

   // Pin registers; second pin is busy unless dual data is live
   always_ff @(posedge clock) begin
      if (reset) begin
         sdo_r      <= 1'b0;
         sdo_oe_r   <= 1'b0;
         busy_pin_r <= 1'b0;
      end else begin
         sdo_r    <= tx_en_r & prim_bit;
         sdo_oe_r <= tx_en_r & ~halt;
         if (cs_s || !tx_en_r || !dual_r)
            busy_pin_r <= busy;
         else
            busy_pin_r <= sec_bit;
      end
   end

   // Outputs straight from flip-flops
   assign serial_data_out   = sdo_r;
   assign serial_data_oe    = sdo_oe_r;
   assign busy_second_out   = busy_pin_r;
   assign sample_hold       = busy;
   assign power_down_active = pd_d_r;
   // Configuration fields for the analog core; 12 and 3 unused
   assign channel_count_sel = cfg_r[`ASR_CFG_CH_HI:`ASR_CFG_CH_LO];
   assign gain_select       = cfg_r[`ASR_CFG_GAIN_HI:`ASR_CFG_GAIN_LO];
   assign int_ref_enable    = cfg_r[`ASR_CFG_REF_EN];
   assign conv_mode_select  = cfg_r[`ASR_CFG_CONV_MODE];

endmodule

// ===== tb/asr_props.sv
`timescale 1ns/10ps
// Pin-level checker for the readout and configuration port
module asr_props #(
   parameter int unsigned CLK_MHZ   = 250,
   parameter int unsigned NORMAL_NS = 1000,
   parameter int unsigned WARP_NS   = 800
) (
   // System
   input wire logic         clock,
   input wire logic         reset,
   // Host pins
   input wire logic         reset_pin_in,
   input wire logic         power_down_in,
   input wire logic         convert_start,
   input wire logic         cs_n_in,
   input wire logic         sclk_in,
   input wire logic         serial_data_in,
   input wire logic         serial_data_out,
   input wire logic         serial_data_oe,
   input wire logic         busy_second_out,
   // Core side
   input wire logic [127:0] channel_data_in,
   input wire logic         sample_hold,
   input wire logic         power_down_active,
   input wire logic [1:0]   channel_count_sel,
   input wire logic [7:0]   gain_select,
   input wire logic         int_ref_enable,
   input wire logic         conv_mode_select
);
   // Clock of the last busy cycle in each mode
   localparam int NORM_D = NORMAL_NS * CLK_MHZ / 1000 - 1;
   localparam int WARP_D = WARP_NS * CLK_MHZ / 1000 - 1;
   logic       hold_q; // Sample-hold one clock back
   logic [5:0] pin_q;  // Recent reset pin levels
   logic [7:0] sck_q;  // Recent serial clock levels
   wire        eoc_w = hold_q & ~sample_hold; // Conversion just ended
   // A serial clock fall seen within the last seven clocks
   wire        fell_w = |(~sck_q[6:0] & sck_q[7:1]);
   wire [11:0] conf_w = {channel_count_sel, gain_select, int_ref_enable,
                         conv_mode_select};

   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   // Pin history; wide enough to cover the synchroniser delay
   always_ff @(posedge clock) begin
      hold_q <= sample_hold;
      pin_q  <= {pin_q[4:0], reset_pin_in};
      sck_q  <= {sck_q[6:0], sclk_in};
   end

   a_oe_select_only: assert property (
      cs_n_in [*6] |-> !serial_data_oe)
      else $error("serial output driven while deselected");
   a_reset_floats: assert property (
      $rose(reset_pin_in) |-> ##[1:5] (!serial_data_oe && !sample_hold))
      else $error("reset pin did not abort");
   a_sleep_floats: assert property (
      $rose(power_down_in) |-> ##[1:5] (!serial_data_oe && !sample_hold))
      else $error("power-down did not abort");
   a_sleep_no_start: assert property (
      power_down_active |-> !$rose(sample_hold))
      else $error("conversion started while asleep");
   a_busy_on_pin: assert property (
      cs_n_in [*6] |-> busy_second_out == $past(sample_hold))
      else $error("second pin not showing busy");
   a_config_at_eoc: assert property (
      $changed(conf_w) |-> eoc_w || $past(eoc_w) || (|pin_q))
      else $error("config pins changed away from conversion end");
   a_default_config: assert property (
      reset_pin_in [*8] |-> conf_w == 12'hFFF)
      else $error("config pins not at default under reset");
   a_bit_on_fall: assert property (
      serial_data_oe && $past(serial_data_oe) && $changed(serial_data_out)
      |-> fell_w)
      else $error("serial bit changed away from a clock fall");
   a_normal_length: assert property (
      disable iff (reset || power_down_in || reset_pin_in)
      $rose(sample_hold) && conv_mode_select
      |-> ##NORM_D sample_hold ##1 !sample_hold)
      else $error("normal conversion length wrong");
   a_warp_length: assert property (
      disable iff (reset || power_down_in || reset_pin_in)
      $rose(sample_hold) && !conv_mode_select
      |-> ##WARP_D sample_hold ##1 !sample_hold)
      else $error("warp conversion length wrong");
endmodule

bind asr_readout_port asr_props #(.CLK_MHZ(CLK_MHZ), .NORMAL_NS(NORMAL_NS),
   .WARP_NS(WARP_NS)) chk (.clock(clock), .reset(reset),
   .reset_pin_in(reset_pin_in), .power_down_in(power_down_in),
   .convert_start(convert_start), .cs_n_in(cs_n_in), .sclk_in(sclk_in),
   .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
   .serial_data_oe(serial_data_oe), .busy_second_out(busy_second_out),
   .channel_data_in(channel_data_in), .sample_hold(sample_hold),
   .power_down_active(power_down_active),
   .channel_count_sel(channel_count_sel), .gain_select(gain_select),
   .int_ref_enable(int_ref_enable), .conv_mode_select(conv_mode_select));

// ===== tb/asr_host.sv
`timescale 1ns/10ps
// Host serial master: starts conversions and runs framed transfers
module asr_host (
   // Clock
   input  wire logic clock,
   // From the device
   input  wire logic serial_data_out,
   input  wire logic serial_data_oe,
   input  wire logic busy_second_out,
   // To the device
   output logic      convert_start,
   output logic      cs_n_in,
   output logic      sclk_in,
   output logic      serial_data_in
);
   localparam int HALF = 8; // Half of a 64 ns serial clock
   int gap = 2;             // Idle clocks after conversion end, slow host

   initial begin
      convert_start = 1'b0;
      cs_n_in = 1'b1;
      sclk_in = 1'b0;
      serial_data_in = 1'b0;
   end

   // Undriven data line between frames: toggles so no level is trusted
   always @(posedge clock) if (cs_n_in) serial_data_in <= ~serial_data_in;

   // Start pulse, then stay off the bus until busy drops
   task automatic conv();
      int n;
      n = 0;
      convert_start <= 1'b1;
      repeat (HALF) @(posedge clock);
      convert_start <= 1'b0;
      while (busy_second_out !== 1'b0 && n < 400) begin
         @(posedge clock);
         n++;
      end
      repeat (gap) @(posedge clock);
   endtask

   // Framed transfer; device bits taken just before each rising edge
   task automatic xfer(input int nb, input logic [15:0] w,
                       output logic [143:0] d1, output logic [143:0] d2);
      d1 = '0;
      d2 = '0;
      cs_n_in <= 1'b0;
      @(posedge clock);
      for (int i = 0; i < nb; i++) begin
         serial_data_in <= (i < 16) ? w[15-i] : 1'b0;
         repeat (HALF) @(posedge clock);
         // Released line reads as the inverse, so a float shows up
         d1 = {d1[142:0], serial_data_oe ? serial_data_out : ~serial_data_out};
         d2 = {d2[142:0], busy_second_out};
         sclk_in <= 1'b1;
         repeat (HALF) @(posedge clock);
         sclk_in <= 1'b0;
      end
      cs_n_in <= 1'b1;
      repeat (HALF) @(posedge clock);
   endtask
endmodule

// ===== tb/adc_serial_readout_config_port_bench.sv
`timescale 1ns/10ps
// Bench: random readouts, config pipeline, device reset and sleep
module adc_serial_readout_config_port_bench;
   localparam int ACQ = 100; // Acquisition wait after a device reset
   logic         clock = 1'b0, reset = 1'b1;
   logic         reset_pin_in = 1'b0, power_down_in = 1'b0;
   logic [127:0] channel_data_in = '0, res = '0; // Stimulus, stored result
   logic [143:0] d1, d2;        // Streams seen on both data pins
   logic [31:0]  lfsr = 32'h4DE81699;
   logic [15:0]  act, pend, w;  // Applied, pending and written config
   logic         pv = 1'b0;     // Pending word waits for conversion end
   int           zc = 0, mismatches = 0, compares = 0;
   logic         convert_start, cs_n_in, sclk_in, serial_data_in;
   logic         serial_data_out, serial_data_oe, busy_second_out;
   logic         sample_hold, power_down_active, int_ref_enable;
   logic         conv_mode_select;
   logic [1:0]   channel_count_sel;
   logic [7:0]   gain_select;
   wire  [11:0]  conf_w = {channel_count_sel, gain_select, int_ref_enable,
                           conv_mode_select};

   always #2 clock = ~clock;

   asr_readout_port dut (.clock(clock), .reset(reset),
      .reset_pin_in(reset_pin_in), .power_down_in(power_down_in),
      .convert_start(convert_start), .cs_n_in(cs_n_in), .sclk_in(sclk_in),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe), .busy_second_out(busy_second_out),
      .channel_data_in(channel_data_in), .sample_hold(sample_hold),
      .power_down_active(power_down_active),
      .channel_count_sel(channel_count_sel), .gain_select(gain_select),
      .int_ref_enable(int_ref_enable), .conv_mode_select(conv_mode_select));
   asr_host host (.clock(clock), .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe),
      .busy_second_out(busy_second_out), .convert_start(convert_start),
      .cs_n_in(cs_n_in), .sclk_in(sclk_in), .serial_data_in(serial_data_in));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected stream, first bit at the top; sec picks the second pin
   function automatic logic [143:0] exp_stream(input logic [127:0] d,
         input logic [15:0] c, input logic sec);
      logic [143:0] s;
      int n;
      s = '0;
      n = c[0] ? 2 * (c[14:13] + 1) : 4;
      if (sec && c[0]) return s;
      for (int k = 0; k < n; k++) s[143-16*k -: 16] = d[16*(k+4*sec) +: 16];
      if (!sec) s[143-16*n -: 16] = c;
      return s;
   endfunction

   task automatic check(input string what, input logic [143:0] seen,
                        input logic [143:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Device reset pulse, then the acquisition wait
   task automatic pin_reset();
      reset_pin_in <= 1'b1;
      repeat (12) @(posedge clock);
      reset_pin_in <= 1'b0;
      act = 16'hFFFF;
      pv = 1'b0;
      res = '0;
      repeat (ACQ) @(posedge clock);
   endtask

   // Conversion, then the model's end-of-conversion update
   task automatic conv();
      host.conv();
      // A host wait that ran out leaves busy high and fails here
      check("busy end", busy_second_out, 1'b0);
      res = (zc > 0) ? '0 : channel_data_in;
      if (zc > 0) zc--;
      if (pv) act = pend;
      pv = 1'b0;
      check("config pins", conf_w, {act[14:13], act[11:4], act[2:1]});
   endtask

   // Framed read; a short frame must not capture the config word
   task automatic rd(input int nb, input logic [15:0] wd);
      int sh;
      sh = 144 - nb;
      host.xfer(nb, wd, d1, d2);
      check("main data", d1, exp_stream(res, act, 1'b0) >> sh);
      check("second data", d2, exp_stream(res, act, 1'b1) >> sh);
      if (nb >= 16 && wd[15]) begin
         pend = wd;
         pv = 1'b1;
      end
   endtask

   initial begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      pin_reset();
      for (int it = 0; it < 12; it++) begin
         for (int j = 0; j < 4; j++) begin
            lfsr = lfsr_next(lfsr);
            channel_data_in[32*j +: 32] <= lfsr;
         end
         host.gap = int'(lfsr[4:0]) + 1;
         conv();
         w = {((it < 8) ? 1'b1 : lfsr[15]), it[2:1], lfsr[12:0]};
         rd((it % 4 == 3) ? 12 : 144, w);
      end
      // Sleep in mid-conversion: aborted, config kept, two dead results
      conv();
      fork
         host.conv();
         begin
            repeat (40) @(posedge clock);
            power_down_in <= 1'b1;
            repeat (20) @(posedge clock);
            check("sleep flag", power_down_active, 1'b1);
            check("sleep hold", sample_hold, 1'b0);
            power_down_in <= 1'b0;
            repeat (10) @(posedge clock);
            check("wake flag", power_down_active, 1'b0);
         end
      join
      check("sleep config", conf_w, {act[14:13], act[11:4], act[2:1]});
      zc = 2;
      for (int k = 0; k < 3; k++) begin
         conv();
         rd(144, 16'h0000);
      end
      pin_reset();
      rd(144, 16'h0000);
      conclude();
   end

   // Watchdog at about twice the expected run of 35000 clocks
   initial begin
      #320000;
      mismatches++;
      conclude();
   end
endmodule
